// File: hw/boot_write_cmd.sv
// Boot write command handler: packet checks, status replies, flash programming
//
// Behaviour
// - Data packet: 81h, N+1, 13h, payload, sum, 03h
// - OK status: 81h, 000Ah, 13h, 00h, fill words
// - Error status: response 93h, code, detail, address
// - Drop bytes until command start byte
// - Command: end byte, checksum, then length checks
// - Acceptance error: lifecycle forbids or pending reset
// - Parameter error: order, range or kind mismatch
// - Parameter error: unit zero or misaligned addresses
// - Invalid address error beyond boundary limit
// - Secure error: lowest level, or middle touching secure
// - Protection error: protected block or locked area
// - On error: no processing, status, hunt command
// - All checks pass: OK, then expect data
// - Drop bytes until data start byte
// - Data: end byte, checksum, then length and response packet errors
// - Parameter error: overrun or unit-misaligned payload size
// - Non-final packet: OK first, then program
// - Non-final failure: next packet gets flash error
// - Final packet: program, then OK or error
// - Driver error: flash error, hunt command
// - Only highest-priority error; flash status and address for program failures, fill words for driver errors
module boot_write_cmd #(
  parameter int PAY_MAX = bw_pkg::PAYLOAD_MAX
) (
  input wire logic MCLK_I,
  input wire logic SYS_RST_I,
  input wire logic [7:0] RX_DATA_I,
  input wire logic RX_VALID_I,
  output logic RX_READY_O,
  output logic [7:0] TX_DATA_O,
  output logic TX_VALID_O,
  input wire logic TX_READY_I,
  input wire logic LIFECYCLE_OK_I,
  input wire logic ENC_RESET_PEND_I,
  input wire logic [1:0] AUTH_LEVEL_I,
  input wire logic [31:0] CODE_START_I,
  input wire logic [31:0] CODE_END_I,
  input wire logic [31:0] CODE_WAU_I,
  input wire logic [31:0] EXT_START_I,
  input wire logic [31:0] EXT_END_I,
  input wire logic [31:0] EXT_WAU_I,
  input wire logic [31:0] BOUND_LIMIT_I,
  input wire logic [31:0] SECURE_END_I,
  input wire logic [31:0] PROT_START_I,
  input wire logic [31:0] PROT_END_I,
  input wire logic [31:0] LOCK_START_I,
  input wire logic [31:0] LOCK_END_I,
  output logic PROG_REQ_O,
  output logic [31:0] PROG_ADDR_O,
  output logic [7:0] PROG_DATA_O,
  input wire logic PROG_DONE_I,
  input wire logic PROG_ERR_I,
  input wire logic PROG_DRV_ERR_I,
  input wire logic [31:0] PROG_STATUS_I
);
  localparam int AW = $clog2(PAY_MAX);

  bw_pkg::state_t state_q;
  bw_pkg::state_t after_q;
  logic rx_ready_q;
  logic is_data_q;
  logic [15:0] len_q;
  logic len_bad_q;
  logic [15:0] body_idx_q;
  logic [7:0] sum_q;
  logic etx_bad_q;
  logic [7:0] code_q;
  logic [63:0] addr_sh_q;
  logic [7:0] resp_in_q;
  logic [31:0] cur_addr_q;
  logic [31:0] end_addr_q;
  logic [31:0] wau_q;
  logic final_q;
  logic fail_pend_q;
  logic [31:0] fail_det_q;
  logic [31:0] fail_adr_q;
  logic [7:0] tx_res_q;
  logic [7:0] tx_sts_q;
  logic [31:0] tx_det_q;
  logic [31:0] tx_adr_q;
  logic [3:0] tx_idx_q;
  logic [15:0] prog_idx_q;
  logic prog_req_q;
  logic [31:0] prog_addr_q;
  logic [7:0] prog_data_q;
  logic [7:0] pay_mem [PAY_MAX];

  logic take;
  logic buf_ready;
  logic tx_push;
  logic [7:0] tx_byte;
  logic [7:0] stat_sum;
  logic [31:0] range_start_address;
  logic [31:0] ead;
  logic s_code, s_ext, e_code, e_ext;
  logic [31:0] write_access_unit;
  logic [7:0] cmd_sts;
  logic [7:0] dat_sts;
  logic [15:0] pay_n;
  logic [31:0] last_addr;
  logic is_final;

  function automatic logic in_rng(input logic [31:0] a, lo, hi);
    return (a >= lo) && (a <= hi);
  endfunction : in_rng

  function automatic logic overlap(input logic [31:0] s, e, lo, hi);
    return (lo <= hi) && (s <= hi) && (e >= lo);
  endfunction : overlap

  function automatic logic [7:0] word_byte(input logic [31:0] w, input logic [1:0] k);
    return w[8*(3-k) +: 8];
  endfunction : word_byte

  assign take = RX_VALID_I && rx_ready_q;
  assign RX_READY_O = rx_ready_q;
  assign PROG_REQ_O = prog_req_q;
  assign PROG_ADDR_O = prog_addr_q;
  assign PROG_DATA_O = prog_data_q;
  assign range_start_address = addr_sh_q[63:32];
  assign ead = addr_sh_q[31:0];
  assign s_code = in_rng(range_start_address, CODE_START_I, CODE_END_I);
  assign s_ext = in_rng(range_start_address, EXT_START_I, EXT_END_I);
  assign e_code = in_rng(ead, CODE_START_I, CODE_END_I);
  assign e_ext = in_rng(ead, EXT_START_I, EXT_END_I);
  assign write_access_unit = s_ext ? EXT_WAU_I : CODE_WAU_I;
  assign pay_n = len_q - 16'h0001;
  assign last_addr = cur_addr_q + {16'h0000, pay_n} - 32'h00000001;
  assign is_final = (last_addr == end_addr_q);

  // Command checks in priority order, first hit reported
  always_comb begin
    if (etx_bad_q) begin
      cmd_sts = bw_pkg::STS_PACKET;
    end else if (sum_q != 8'h00) begin
      cmd_sts = bw_pkg::STS_CHECKSUM;
    end else if (len_bad_q || len_q != bw_pkg::CMD_LEN || code_q != bw_pkg::WRITE_CODE) begin
      cmd_sts = bw_pkg::STS_PACKET;
    end else if (!LIFECYCLE_OK_I || ENC_RESET_PEND_I) begin
      cmd_sts = bw_pkg::STS_ACCEPT;
    end else if (range_start_address > ead || !(s_code || s_ext) || !(e_code || e_ext) || s_ext != e_ext) begin
      cmd_sts = bw_pkg::STS_PARAM;
    end else if (write_access_unit == 32'h0 || (range_start_address & (write_access_unit - 32'h1)) != 32'h0
                 || ((ead + 32'h1) & (write_access_unit - 32'h1)) != 32'h0) begin
      cmd_sts = bw_pkg::STS_PARAM;
    end else if (ead > BOUND_LIMIT_I) begin
      cmd_sts = bw_pkg::STS_INV_ADDR;
    end else if (AUTH_LEVEL_I == bw_pkg::AUTH_LOWEST
                 || (AUTH_LEVEL_I == bw_pkg::AUTH_MIDDLE && range_start_address < SECURE_END_I)) begin
      cmd_sts = bw_pkg::STS_SECURE;
    end else if (overlap(range_start_address, ead, PROT_START_I, PROT_END_I)
                 || overlap(range_start_address, ead, LOCK_START_I, LOCK_END_I)) begin
      cmd_sts = bw_pkg::STS_PROTECT;
    end else begin
      cmd_sts = bw_pkg::STS_OK;
    end
  end

  // Data packet checks in priority order
  always_comb begin
    if (etx_bad_q) begin
      dat_sts = bw_pkg::STS_PACKET;
    end else if (sum_q != 8'h00) begin
      dat_sts = bw_pkg::STS_CHECKSUM;
    end else if (len_bad_q || len_q < bw_pkg::MIN_DATA_LEN || resp_in_q != bw_pkg::RESP_OK) begin
      dat_sts = bw_pkg::STS_PACKET;
    end else if (last_addr > end_addr_q || ({16'h0000, pay_n} & (wau_q - 32'h1)) != 32'h0) begin
      dat_sts = bw_pkg::STS_PARAM;
    end else begin
      dat_sts = bw_pkg::STS_OK;
    end
  end

  // Status packet byte stream
  assign stat_sum = 8'h00 - (bw_pkg::STAT_LEN[15:8] + bw_pkg::STAT_LEN[7:0] + tx_res_q + tx_sts_q
    + tx_det_q[31:24] + tx_det_q[23:16] + tx_det_q[15:8] + tx_det_q[7:0]
    + tx_adr_q[31:24] + tx_adr_q[23:16] + tx_adr_q[15:8] + tx_adr_q[7:0]);

  always_comb begin
    if (tx_idx_q == bw_pkg::SP_START) begin
      tx_byte = bw_pkg::DATA_START_BYTE;
    end else if (tx_idx_q == bw_pkg::SP_LENH) begin
      tx_byte = bw_pkg::STAT_LEN[15:8];
    end else if (tx_idx_q == bw_pkg::SP_LENL) begin
      tx_byte = bw_pkg::STAT_LEN[7:0];
    end else if (tx_idx_q == bw_pkg::SP_RES) begin
      tx_byte = tx_res_q;
    end else if (tx_idx_q == bw_pkg::SP_STS) begin
      tx_byte = tx_sts_q;
    end else if (tx_idx_q < bw_pkg::SP_ADR) begin
      tx_byte = word_byte(tx_det_q, 2'(tx_idx_q - bw_pkg::SP_DET));
    end else if (tx_idx_q < bw_pkg::SP_SUM) begin
      tx_byte = word_byte(tx_adr_q, 2'(tx_idx_q - bw_pkg::SP_ADR));
    end else if (tx_idx_q == bw_pkg::SP_SUM) begin
      tx_byte = stat_sum;
    end else begin
      tx_byte = bw_pkg::PACKET_END_BYTE;
    end
  end

  assign tx_push = (state_q == bw_pkg::SEND) && buf_ready;

  byte_skid_buf #(.WIDTH(8)) u_tx_buf (
    .clk_i(MCLK_I),
    .rst_i(SYS_RST_I),
    .in_valid_i(state_q == bw_pkg::SEND),
    .in_data_i(tx_byte),
    .in_ready_o(buf_ready),
    .out_valid_o(TX_VALID_O),
    .out_data_o(TX_DATA_O),
    .out_ready_i(TX_READY_I)
  );

  // Payload store
  always_ff @(posedge MCLK_I) begin
    if (state_q == bw_pkg::RX_BODY && take && is_data_q && body_idx_q != 16'h0) begin
      pay_mem[AW'(body_idx_q - 16'h1)] <= RX_DATA_I;
    end
  end

  task automatic report(input logic [7:0] res, sts, input logic [31:0] det, adr,
                        input bw_pkg::state_t nxt);
    tx_res_q <= res;
    tx_sts_q <= sts;
    tx_det_q <= det;
    tx_adr_q <= adr;
    tx_idx_q <= bw_pkg::SP_START;
    after_q <= nxt;
    state_q <= bw_pkg::SEND;
  endtask : report

  // Main sequence: receive, check, reply, program
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      state_q <= bw_pkg::HUNT_CMD;
      after_q <= bw_pkg::HUNT_CMD;
      rx_ready_q <= 1'b1;
      is_data_q <= 1'b0;
      len_q <= 16'h0;
      len_bad_q <= 1'b0;
      body_idx_q <= 16'h0;
      sum_q <= 8'h00;
      etx_bad_q <= 1'b0;
      code_q <= 8'h00;
      addr_sh_q <= bw_pkg::ADDR_SH_RST;
      resp_in_q <= 8'h00;
      cur_addr_q <= 32'h0;
      end_addr_q <= 32'h0;
      wau_q <= 32'h0;
      final_q <= 1'b0;
      fail_pend_q <= 1'b0;
      fail_det_q <= bw_pkg::FILL_WORD;
      fail_adr_q <= bw_pkg::FILL_WORD;
      tx_res_q <= bw_pkg::RESP_OK;
      tx_sts_q <= bw_pkg::STS_OK;
      tx_det_q <= bw_pkg::FILL_WORD;
      tx_adr_q <= bw_pkg::FILL_WORD;
      tx_idx_q <= bw_pkg::SP_START;
      prog_idx_q <= 16'h0;
      prog_req_q <= 1'b0;
      prog_addr_q <= 32'h0;
      prog_data_q <= 8'h00;
    end else begin
      case (state_q)
        bw_pkg::HUNT_CMD, bw_pkg::HUNT_DATA: begin
          if (take && RX_DATA_I == (state_q == bw_pkg::HUNT_CMD ?
              bw_pkg::CMD_START_BYTE : bw_pkg::DATA_START_BYTE)) begin
            is_data_q <= (state_q == bw_pkg::HUNT_DATA);
            sum_q <= 8'h00;
            etx_bad_q <= 1'b0;
            len_bad_q <= 1'b0;
            state_q <= bw_pkg::RX_LENH;
          end
        end
        bw_pkg::RX_LENH: begin
          if (take) begin
            len_q[15:8] <= RX_DATA_I;
            sum_q <= sum_q + RX_DATA_I;
            state_q <= bw_pkg::RX_LENL;
          end
        end
        bw_pkg::RX_LENL: begin
          if (take) begin
            len_q[7:0] <= RX_DATA_I;
            sum_q <= sum_q + RX_DATA_I;
            body_idx_q <= 16'h0;
            if ({len_q[15:8], RX_DATA_I} == 16'h0
                || {len_q[15:8], RX_DATA_I} > bw_pkg::MAX_LEN) begin
              len_bad_q <= 1'b1;
              state_q <= bw_pkg::RX_SUM;
            end else begin
              state_q <= bw_pkg::RX_BODY;
            end
          end
        end
        bw_pkg::RX_BODY: begin
          if (take) begin
            sum_q <= sum_q + RX_DATA_I;
            body_idx_q <= body_idx_q + 16'h1;
            if (body_idx_q == 16'h0) begin
              code_q <= RX_DATA_I;
              resp_in_q <= RX_DATA_I;
            end else if (!is_data_q) begin
              addr_sh_q <= {addr_sh_q[55:0], RX_DATA_I};
            end
            if (body_idx_q == len_q - 16'h1) begin
              state_q <= bw_pkg::RX_SUM;
            end
          end
        end
        bw_pkg::RX_SUM: begin
          if (take) begin
            sum_q <= sum_q + RX_DATA_I;
            state_q <= bw_pkg::RX_END;
          end
        end
        bw_pkg::RX_END: begin
          if (take) begin
            etx_bad_q <= (RX_DATA_I != bw_pkg::PACKET_END_BYTE);
            rx_ready_q <= 1'b0;
            state_q <= is_data_q ? bw_pkg::DATA_CHECK : bw_pkg::CMD_CHECK;
          end
        end
        bw_pkg::CMD_CHECK: begin
          if (cmd_sts != bw_pkg::STS_OK) begin
            report(bw_pkg::RESP_ERR, cmd_sts, bw_pkg::FILL_WORD, bw_pkg::FILL_WORD,
                   bw_pkg::HUNT_CMD);
          end else begin
            cur_addr_q <= range_start_address;
            end_addr_q <= ead;
            wau_q <= write_access_unit;
            fail_pend_q <= 1'b0;
            report(bw_pkg::RESP_OK, bw_pkg::STS_OK, bw_pkg::FILL_WORD, bw_pkg::FILL_WORD,
                   bw_pkg::HUNT_DATA);
          end
        end
        bw_pkg::DATA_CHECK: begin
          prog_idx_q <= 16'h0;
          final_q <= is_final;
          if (dat_sts != bw_pkg::STS_OK) begin
            report(bw_pkg::RESP_ERR, dat_sts, bw_pkg::FILL_WORD, bw_pkg::FILL_WORD,
                   bw_pkg::HUNT_CMD);
          end else if (fail_pend_q) begin
            report(bw_pkg::RESP_ERR, bw_pkg::STS_FLASH, fail_det_q, fail_adr_q,
                   bw_pkg::HUNT_CMD);
          end else if (is_final) begin
            state_q <= bw_pkg::PROG_LOAD;
          end else begin
            report(bw_pkg::RESP_OK, bw_pkg::STS_OK, bw_pkg::FILL_WORD, bw_pkg::FILL_WORD,
                   bw_pkg::PROG_LOAD);
          end
        end
        bw_pkg::SEND: begin
          if (tx_push) begin
            tx_idx_q <= tx_idx_q + 4'h1;
            if (tx_idx_q == bw_pkg::SP_LAST) begin
              state_q <= after_q;
              rx_ready_q <= (after_q != bw_pkg::PROG_LOAD);
            end
          end
        end
        bw_pkg::PROG_LOAD: begin
          prog_data_q <= pay_mem[AW'(prog_idx_q)];
          prog_addr_q <= cur_addr_q + {16'h0000, prog_idx_q};
          prog_req_q <= 1'b1;
          state_q <= bw_pkg::PROG_WAIT;
        end
        default: begin
          if (PROG_DONE_I) begin
            prog_req_q <= 1'b0;
            prog_idx_q <= prog_idx_q + 16'h1;
            if (PROG_DRV_ERR_I) begin
              report(bw_pkg::RESP_ERR, bw_pkg::STS_FLASH, bw_pkg::FILL_WORD, bw_pkg::FILL_WORD,
                     bw_pkg::HUNT_CMD);
            end else if (PROG_ERR_I && final_q) begin
              report(bw_pkg::RESP_ERR, bw_pkg::STS_FLASH, PROG_STATUS_I, prog_addr_q,
                     bw_pkg::HUNT_CMD);
            end else if (PROG_ERR_I || prog_idx_q == pay_n - 16'h1) begin
              cur_addr_q <= cur_addr_q + {16'h0000, pay_n};
              if (PROG_ERR_I) begin
                fail_pend_q <= 1'b1;
                fail_det_q <= PROG_STATUS_I;
                fail_adr_q <= prog_addr_q;
              end
              if (final_q) begin
                report(bw_pkg::RESP_OK, bw_pkg::STS_OK, bw_pkg::FILL_WORD, bw_pkg::FILL_WORD,
                       bw_pkg::HUNT_CMD);
              end else begin
                state_q <= bw_pkg::HUNT_DATA;
                rx_ready_q <= 1'b1;
              end
            end else begin
              state_q <= bw_pkg::PROG_LOAD;
            end
          end
        end
      endcase
    end
  end

  default clocking dc @(posedge MCLK_I); endclocking
  default disable iff (SYS_RST_I);

  property p_hunt_drop;
    state_q == bw_pkg::HUNT_CMD && take && RX_DATA_I != bw_pkg::CMD_START_BYTE
      |=> state_q == bw_pkg::HUNT_CMD;
  endproperty
  a_hunt_drop: assert property (p_hunt_drop) else $error("Stray byte left hunt");
  property p_ok_fields;
    state_q == bw_pkg::SEND && tx_sts_q == bw_pkg::STS_OK |-> tx_res_q == bw_pkg::RESP_OK
      && tx_det_q == bw_pkg::FILL_WORD && tx_adr_q == bw_pkg::FILL_WORD;
  endproperty
  a_ok_fields: assert property (p_ok_fields) else $error("Bad OK status fields");
  property p_err_res;
    state_q == bw_pkg::SEND && tx_sts_q != bw_pkg::STS_OK |-> tx_res_q == bw_pkg::RESP_ERR;
  endproperty
  a_err_res: assert property (p_err_res) else $error("Bad error response byte");
  property p_etx_first;
    state_q == bw_pkg::CMD_CHECK && etx_bad_q |-> cmd_sts == bw_pkg::STS_PACKET;
  endproperty
  a_etx_first: assert property (p_etx_first) else $error("End byte not first check");
  property p_cmd_err;
    state_q == bw_pkg::CMD_CHECK && cmd_sts != bw_pkg::STS_OK
      |=> state_q == bw_pkg::SEND && after_q == bw_pkg::HUNT_CMD && !prog_req_q;
  endproperty
  a_cmd_err: assert property (p_cmd_err) else $error("Command error not aborted");
  property p_low_auth;
    state_q == bw_pkg::CMD_CHECK && AUTH_LEVEL_I == bw_pkg::AUTH_LOWEST
      |-> cmd_sts != bw_pkg::STS_OK;
  endproperty
  a_low_auth: assert property (p_low_auth) else $error("Lowest level accepted");
  property p_ok_first;
    state_q == bw_pkg::DATA_CHECK && dat_sts == bw_pkg::STS_OK && !fail_pend_q && !is_final
      |=> state_q == bw_pkg::SEND && after_q == bw_pkg::PROG_LOAD;
  endproperty
  a_ok_first: assert property (p_ok_first) else $error("Non-final not acked first");
  property p_prog_hold;
    prog_req_q && !PROG_DONE_I |=> prog_req_q && $stable(prog_addr_q) && $stable(prog_data_q);
  endproperty
  a_prog_hold: assert property (p_prog_hold) else $error("Program request dropped");
  property p_send_frame;
    tx_push && tx_idx_q == bw_pkg::SP_LAST |-> tx_byte == bw_pkg::PACKET_END_BYTE ##1
      state_q != bw_pkg::SEND;
  endproperty
  a_send_frame: assert property (p_send_frame) else $error("Status frame overran");

  c_cmd_ok: cover property (state_q == bw_pkg::CMD_CHECK && cmd_sts == bw_pkg::STS_OK);
  c_final_ok: cover property (state_q == bw_pkg::PROG_WAIT && PROG_DONE_I && final_q);
  c_fail_pend: cover property (state_q == bw_pkg::DATA_CHECK && fail_pend_q);
  c_tx_stall: cover property (TX_VALID_O && !TX_READY_I && !buf_ready);
endmodule : boot_write_cmd

// File: hw/bw_pkg.sv
// Constants and types shared by the boot write command handler
package bw_pkg;
  localparam logic [7:0] CMD_START_BYTE = 8'h01;
  localparam logic [7:0] DATA_START_BYTE = 8'h81;
  localparam logic [7:0] PACKET_END_BYTE = 8'h03;
  localparam logic [7:0] WRITE_CODE = 8'h13;
  localparam logic [7:0] RESP_OK = 8'h13;
  localparam logic [7:0] RESP_ERR = 8'h93;
  localparam logic [15:0] CMD_LEN = 16'h0009;
  localparam logic [15:0] STAT_LEN = 16'h000A;
  localparam logic [15:0] MIN_DATA_LEN = 16'h0002;
  localparam logic [15:0] MAX_LEN = 16'h0401;
  localparam int PAYLOAD_MAX = 1024;
  localparam logic [31:0] FILL_WORD = 32'h0FFFFFFF;
  // Status codes, all distinct; only STS_OK is zero
  localparam logic [7:0] STS_OK = 8'h00;
  localparam logic [7:0] STS_PACKET = 8'hC1;
  localparam logic [7:0] STS_CHECKSUM = 8'hC2;
  localparam logic [7:0] STS_ACCEPT = 8'hC3;
  localparam logic [7:0] STS_PARAM = 8'hC4;
  localparam logic [7:0] STS_INV_ADDR = 8'hD0;
  localparam logic [7:0] STS_SECURE = 8'hDA;
  localparam logic [7:0] STS_PROTECT = 8'hDB;
  localparam logic [7:0] STS_FLASH = 8'hE1;
  // Status packet byte positions
  localparam logic [3:0] SP_START = 4'h0;
  localparam logic [3:0] SP_LENH = 4'h1;
  localparam logic [3:0] SP_LENL = 4'h2;
  localparam logic [3:0] SP_RES = 4'h3;
  localparam logic [3:0] SP_STS = 4'h4;
  localparam logic [3:0] SP_DET = 4'h5;
  localparam logic [3:0] SP_ADR = 4'h9;
  localparam logic [3:0] SP_SUM = 4'hD;
  localparam logic [3:0] SP_LAST = 4'hE;
  localparam logic [1:0] AUTH_LOWEST = 2'h0;
  localparam logic [1:0] AUTH_MIDDLE = 2'h1;
  localparam logic [63:0] ADDR_SH_RST = 64'h0;
  typedef enum logic [3:0] {
    HUNT_CMD, HUNT_DATA, RX_LENH, RX_LENL, RX_BODY, RX_SUM, RX_END,
    CMD_CHECK, DATA_CHECK, SEND, PROG_LOAD, PROG_WAIT
  } state_t;
endpackage : bw_pkg

// File: hw/byte_skid_buf.sv
// Two-entry buffer with valid and ready on both sides
module byte_skid_buf #(
  parameter int WIDTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  logic [WIDTH-1:0] head_q;
  logic [WIDTH-1:0] tail_q;
  logic head_v_q;
  logic tail_v_q;
  logic push;
  logic pop;

  assign in_ready_o = !tail_v_q;
  assign out_valid_o = head_v_q;
  assign out_data_o = head_q;
  assign push = in_valid_i && !tail_v_q;
  assign pop = head_v_q && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      head_v_q <= 1'b0;
      tail_v_q <= 1'b0;
      head_q <= '0;
      tail_q <= '0;
    end else if (pop && tail_v_q) begin
      head_q <= tail_q;
      tail_v_q <= 1'b0;
    end else if (!head_v_q || pop) begin
      head_v_q <= push;
      if (push) begin
        head_q <= in_data_i;
      end
    end else if (push) begin
      tail_q <= in_data_i;
      tail_v_q <= 1'b1;
    end
  end
endmodule : byte_skid_buf

// File: verif/boot_write_cmd_tb_top.sv
// Testbench for the boot write command handler
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin mismatches++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module boot_write_cmd_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, rst = 1'b1, lc = 1'b1, en = 1'b0, fe = 1'b0, de = 1'b0, done = 1'b0;
  logic [1:0] au = 2'h2;
  logic [31:0] cs = 32'h0, ce = 32'hFFFF, xs = 32'h10000000, xe = 32'h1000FFFF;
  logic [31:0] bl = 32'h10007FFF, ps = 32'h400, pe = 32'h4FF, ks = 32'h500, ke = 32'h5FF;
  wire logic [7:0] rxd, txd, pdat;
  wire logic rxv, rxr, txv, txr, preq, hang;
  wire logic [31:0] padr;
  logic [31:0] pa[$];
  logic [7:0] pd[$];
  int mismatches = 0, samples_checked = 0;
  always #10 mclk = ~mclk;
  boot_write_cmd dut_u (.MCLK_I(mclk), .SYS_RST_I(rst), .RX_DATA_I(rxd), .RX_VALID_I(rxv),
    .RX_READY_O(rxr), .TX_DATA_O(txd), .TX_VALID_O(txv), .TX_READY_I(txr),
    .LIFECYCLE_OK_I(lc), .ENC_RESET_PEND_I(en), .AUTH_LEVEL_I(au), .CODE_START_I(cs),
    .CODE_END_I(ce), .CODE_WAU_I(32'h4), .EXT_START_I(xs), .EXT_END_I(xe),
    .EXT_WAU_I(32'h4), .BOUND_LIMIT_I(bl), .SECURE_END_I(32'h100), .PROT_START_I(ps),
    .PROT_END_I(pe), .LOCK_START_I(ks), .LOCK_END_I(ke), .PROG_REQ_O(preq),
    .PROG_ADDR_O(padr), .PROG_DATA_O(pdat), .PROG_DONE_I(done), .PROG_ERR_I(fe),
    .PROG_DRV_ERR_I(de), .PROG_STATUS_I(32'h5A5A));
  host_model host_u (.clk_i(mclk), .rx_data_o(rxd), .rx_valid_o(rxv), .rx_ready_i(rxr),
    .tx_data_i(txd), .tx_valid_i(txv), .tx_ready_o(txr), .hang_o(hang));
  // Flash side: answers each request one cycle later and logs it
  always @(posedge mclk) begin
    if (preq && done) begin
      pa.push_back(padr);
      pd.push_back(pdat);
    end
    done <= preq && !done;
  end
  always @(posedge mclk) begin
    if (hang === 1'b1) begin
      mismatches++;
      complete_run();
    end
  end
  task complete_run;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  task cmd(input logic [31:0] a, e, input logic [1:0] bad);
    logic [7:0] b[$];
    b = {bw_pkg::WRITE_CODE};
    for (int i = 3; i >= 0; i--) b.push_back(a[8*i+:8]);
    for (int i = 3; i >= 0; i--) b.push_back(e[8*i+:8]);
    host_u.send(bw_pkg::CMD_START_BYTE, b, bad);
  endtask : cmd
  task dat(input int n, input logic [7:0] r);
    logic [7:0] b[$];
    b = {r};
    for (int i = 0; i < n; i++) b.push_back(8'(8'h11 * (i + 1)));
    host_u.send(bw_pkg::DATA_START_BYTE, b, 2'h0);
  endtask : dat
  task stat(input logic [7:0] r, s, input logic [31:0] d, a);
    logic [7:0] st[15];
    logic [119:0] ev;
    ev = {bw_pkg::DATA_START_BYTE, 16'h000A, r, s, d, a, 8'h00, bw_pkg::PACKET_END_BYTE};
    for (int j = 1; j < 13; j++) ev[15:8] = ev[15:8] - ev[119-8*j-:8];
    host_u.recv(st);
    for (int j = 0; j < 15; j++) `CHK(st[j], ev[119-8*j-:8])
  endtask : stat
  task ok_stat;
    stat(bw_pkg::RESP_OK, bw_pkg::STS_OK, bw_pkg::FILL_WORD, bw_pkg::FILL_WORD);
  endtask : ok_stat
  task err_case(input logic [31:0] a, e, input logic [1:0] bad, input logic l, p,
      input logic [1:0] u,
      input logic [7:0] s);
    lc <= l;
    en <= p;
    au <= u;
    pa.delete();
    cmd(a, e, bad);
    stat(bw_pkg::RESP_ERR, s, bw_pkg::FILL_WORD, bw_pkg::FILL_WORD);
    `CHK(pa.size(), 0)
    lc <= 1'b1;
    en <= 1'b0;
    au <= 2'h2;
  endtask : err_case
  task t_write_ok;
    pa.delete();
    cmd(32'h200, 32'h203, 1'b0);
    ok_stat();
    dat(4, bw_pkg::RESP_OK);
    ok_stat();
    `CHK(pa.size(), 4)
    for (int i = 0; i < 4; i++) begin
      `CHK(pa[i], 32'h200 + i)
      `CHK(pd[i], 8'(8'h11 * (i + 1)))
    end
  endtask : t_write_ok
  task t_checks;
    host_u.slow_q = 1'b1;
    err_case(32'h200, 32'h203, 1, 1, 0, 2, bw_pkg::STS_CHECKSUM);
    err_case(32'h200, 32'h203, 3, 1, 0, 2, bw_pkg::STS_PACKET);
    err_case(32'h204, 32'h203, 0, 1, 0, 2, bw_pkg::STS_PARAM);
    err_case(32'h200, 32'h20003, 0, 1, 0, 2, bw_pkg::STS_PARAM);
    err_case(32'hFFFC, 32'h10000003, 0, 1, 0, 2, bw_pkg::STS_PARAM);
    err_case(32'h202, 32'h205, 0, 1, 0, 2, bw_pkg::STS_PARAM);
    err_case(32'h10008000, 32'h10008003, 0, 1, 0, 2, bw_pkg::STS_INV_ADDR);
    err_case(32'h200, 32'h203, 0, 1, 0, 0, bw_pkg::STS_SECURE);
    err_case(32'h0, 32'h3, 0, 1, 0, 1, bw_pkg::STS_SECURE);
    err_case(32'h400, 32'h403, 0, 1, 0, 2, bw_pkg::STS_PROTECT);
    err_case(32'h500, 32'h503, 0, 1, 0, 2, bw_pkg::STS_PROTECT);
    err_case(32'h204, 32'h203, 0, 0, 0, 2, bw_pkg::STS_ACCEPT);
    err_case(32'h200, 32'h203, 0, 1, 1, 2, bw_pkg::STS_ACCEPT);
    host_u.slow_q = 1'b0;
  endtask : t_checks
  task t_data_errs;
    cmd(32'h600, 32'h603, 1'b0);
    ok_stat();
    dat(4, 8'h14);
    stat(bw_pkg::RESP_ERR, bw_pkg::STS_PACKET, bw_pkg::FILL_WORD, bw_pkg::FILL_WORD);
    cmd(32'h600, 32'h603, 1'b0);
    ok_stat();
    dat(8, bw_pkg::RESP_OK);
    stat(bw_pkg::RESP_ERR, bw_pkg::STS_PARAM, bw_pkg::FILL_WORD, bw_pkg::FILL_WORD);
    cmd(32'h600, 32'h607, 1'b0);
    ok_stat();
    dat(2, bw_pkg::RESP_OK);
    stat(bw_pkg::RESP_ERR, bw_pkg::STS_PARAM, bw_pkg::FILL_WORD, bw_pkg::FILL_WORD);
  endtask : t_data_errs
  task t_flash_fail;
    cmd(32'h300, 32'h307, 1'b0);
    ok_stat();
    fe <= 1'b1;
    dat(4, bw_pkg::RESP_OK);
    ok_stat();
    dat(4, bw_pkg::RESP_OK);
    fe <= 1'b0;
    stat(bw_pkg::RESP_ERR, bw_pkg::STS_FLASH, 32'h5A5A, 32'h300);
    cmd(32'h10000000, 32'h10000003, 1'b0);
    ok_stat();
    de <= 1'b1;
    dat(4, bw_pkg::RESP_OK);
    stat(bw_pkg::RESP_ERR, bw_pkg::STS_FLASH, bw_pkg::FILL_WORD, bw_pkg::FILL_WORD);
    de <= 1'b0;
  endtask : t_flash_fail
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_write_ok();
    t_checks();
    t_data_errs();
    t_flash_fail();
    complete_run();
  end
endmodule : boot_write_cmd_tb_top

// File: verif/host_model.sv
// Host tool model: sends packets and collects status replies
module host_model (
  input wire logic clk_i,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  output logic hang_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic slow_q = 1'b0;
  initial begin
    rx_data_o = 8'h00;
    rx_valid_o = 1'b0;
    tx_ready_o = 1'b0;
    hang_o = 1'b0;
  end
  // Junk byte, start byte, length, body, sum, end; each held until taken
  task send(input logic [7:0] sob, input logic [7:0] body[$], input logic [1:0] bad);
    logic [7:0] p[$];
    logic [7:0] s;
    int k;
    s = 8'h00 - 8'(body.size());
    foreach (body[i]) s = s - body[i];
    p = {8'h5A, sob, 8'h00, 8'(body.size())};
    p = {p, body, s ^ {7'h00, bad[0]}, bw_pkg::PACKET_END_BYTE ^ {bad[1], 7'h00}};
    foreach (p[i]) begin
      rx_data_o <= p[i];
      rx_valid_o <= 1'b1;
      k = 0;
      do begin
        @(posedge clk_i);
        k++;
      end while (!rx_ready_i && k < 300);
      if (k >= 300) hang_o <= 1'b1;
    end
    rx_valid_o <= 1'b0;
    rx_data_o <= ~p[$];
  endtask : send
  // Stalls every other cycle when slow
  task recv(output logic [7:0] st[15]);
    int g;
    g = 0;
    for (int k = 0; k < 600 && g < 15; k++) begin
      tx_ready_o <= slow_q ? ~tx_ready_o : 1'b1;
      @(posedge clk_i);
      if (tx_valid_i && tx_ready_o) begin
        st[g] = tx_data_i;
        g++;
      end
    end
    tx_ready_o <= 1'b0;
    if (g < 15) hang_o <= 1'b1;
  endtask : recv
endmodule : host_model
